// >>> logic/ebp_defs.vh
/*
  constants for the external bus pin block: strap meanings, cycle kinds,
  bus state codes, chip select count and address width.
  assumes it is included by its bare name from the design files.
*/
`ifndef EBP_DEFS_VH
`define EBP_DEFS_VH

// ----------------------------------------
// strap meanings
// ----------------------------------------
`define EBP_MODE_MUXED      1'b1
`define EBP_MODE_SEPARATE   1'b0
`define EBP_ORDER_BIG       1'b1
`define EBP_ORDER_LITTLE    1'b0

// ----------------------------------------
// cycle kinds
// ----------------------------------------
`define EBP_KIND_READ       2'h0
`define EBP_KIND_WRITE      2'h1
`define EBP_KIND_DUMMY      2'h2

// ----------------------------------------
// bus controller states, one-hot
// ----------------------------------------
`define EBP_ST_IDLE         5'h01
`define EBP_ST_ADDR         5'h02
`define EBP_ST_DATA         5'h04
`define EBP_ST_DRAIN        5'h08
`define EBP_ST_GRANT        5'h10

// ----------------------------------------
// chip select count and address width
// ----------------------------------------
`define EBP_NUM_CS          4
`define EBP_ADDR_W          24

`endif

// >>> logic/ebp_cs_decode.v
/*
  chip select decoder: one high-active hit per address area.
  assumes base and mask come from steady configuration ports.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ebp_defs.vh"

module ebp_cs_decode #(
  parameter NUM_CS = `EBP_NUM_CS,
  parameter AW     = `EBP_ADDR_W
) (
  input  wire [AW-1:0]        i_addr,
  input  wire                 i_active,
  input  wire [NUM_CS*AW-1:0] i_base,
  input  wire [NUM_CS*AW-1:0] i_mask,
  input  wire [NUM_CS-1:0]    i_enable,
  output wire [NUM_CS-1:0]    o_hit
);

  // ----------------------------------------
  // per-select area compare
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CS; g = g + 1) begin : g_cs
      wire [AW-1:0] m = i_mask[g*AW +: AW];
      wire [AW-1:0] b = i_base[g*AW +: AW];
      assign o_hit[g] = i_active & i_enable[g] & ((i_addr & m) == (b & m)); // see RULE_04
    end
  endgenerate

endmodule // ebp_cs_decode
`default_nettype wire

// >>> logic/ebp_bus_pins.v
/*
  external bus pin block: straps, separate / multiplexed address-data
  mapping, strobes, chip selects, wait/ready, bus hand-over, port fallback
  and the system clock output.
  assumes the core issues one request at a time and holds it until done.
*/
// Behaviour
// (RULE_01) at reset release, bus-mode strap high means multiplexed, low separate
// (RULE_02) at reset release, byte-order strap high means big endian, low little
// (RULE_03) after reset both strap pins are plain port bits only
// (RULE_04) each chip select is low while the address lies in its area
// (RULE_05) read/write line high for read and dummy cycles, low for writes
// (RULE_06) read strobe asserted while reading external memory
// (RULE_07) low write strobe asserted when writing data lines 0 to 7
// (RULE_08) high write strobe asserted when writing data lines 8 to 15
// (RULE_09) address latch strobe active only for external accesses
// (RULE_10) wait input held active extends the current cycle
// (RULE_11) in ready sense the cycle completes when ready is signalled
// (RULE_12) external master holds bus request to ask for the bus
// (RULE_13) on request, release bus drivers, then assert bus grant
// (RULE_14) separate mode: sixteen data lines, address out through line 23
// (RULE_15) multiplexed mode: data pins share address, address 0-7 on port two
// (RULE_16) ports zero, one, two have per-bit direction
// (RULE_17) strobe-shared port bits are output only when not strobes
// (RULE_18) system clock output shows high or low speed clock by selection
// (RULE_19) each shared pin is port unless its bus function is selected
`timescale 1ns/10ps
`default_nettype none
`include "ebp_defs.vh"

module ebp_bus_pins #(
  parameter NUM_CS = `EBP_NUM_CS,
  parameter AW     = `EBP_ADDR_W
) (
  input  wire                 i_clk,
  input  wire                 i_rst,
  // straps, shared with port bits
  input  wire                 i_bus_strap_port_bit,
  input  wire                 i_order_strap_port_bit,
  output reg                  o_bus_mode_muxed,
  output reg                  o_byte_order_big,
  output reg  [1:0]           o_strap_port_in,
  // core request side
  input  wire                 i_req,
  input  wire [1:0]           i_req_kind,
  input  wire [AW-1:0]        i_req_addr,
  input  wire [15:0]          i_req_wdata,
  input  wire [1:0]           i_req_be,
  input  wire                 i_req_external,
  output reg                  o_done,
  output reg  [15:0]          o_rdata,
  // wait / ready
  input  wire                 i_wait_in,
  input  wire                 i_ready_sense,
  // chip select areas
  input  wire [NUM_CS*AW-1:0] i_cs_base,
  input  wire [NUM_CS*AW-1:0] i_cs_mask,
  input  wire [NUM_CS-1:0]    i_cs_enable,
  // bus hand-over
  input  wire                 i_bus_request_in,
  output reg                  o_bus_grant_out,
  // function selects and port registers
  input  wire [3:0]           i_bus_fn_sel,
  input  wire [23:0]          i_port_out,
  input  wire [23:0]          i_port_dir,
  input  wire [1:0]           i_strobe_port_out,
  // clocks for the system clock output
  input  wire                 i_fast_clk_lvl,
  input  wire                 i_slow_clk_lvl,
  input  wire                 i_clk_sel_slow,
  // pins: data/address lines and port two
  input  wire [15:0]          i_data_lines_in,
  output reg  [15:0]          o_data_lines_out,
  output reg  [15:0]          o_data_lines_oe_n,
  output reg  [7:0]           o_port_two_bits_out,
  output reg  [7:0]           o_port_two_bits_oe_n,
  output reg  [15:0]          o_sep_addr_low,
  // strobe pins
  output reg                  o_read_strobe_n,
  output reg                  o_low_write_strobe_n,
  output reg                  o_high_byte_write_strobe_n,
  output reg                  o_read_write,
  output reg                  o_addr_latch,
  output reg  [NUM_CS-1:0]    o_chip_select_n,
  output reg                  o_system_clock_out
);

  // ----------------------------------------
  // function select bits
  // ----------------------------------------
  // bit0 data/addr lines, bit1 port two, bit2 strobes, bit3 chip selects
  localparam ST_IDLE  = `EBP_ST_IDLE;
  localparam ST_ADDR  = `EBP_ST_ADDR;
  localparam ST_DATA  = `EBP_ST_DATA;
  localparam ST_DRAIN = `EBP_ST_DRAIN;
  localparam ST_GRANT = `EBP_ST_GRANT;

  reg [4:0]    state_r;
  reg [4:0]    state_nxt;
  reg          rst_d_r;
  reg [1:0]    kind_r;
  reg [AW-1:0] addr_r;
  reg [15:0]   wdata_r;
  reg [1:0]    be_r;
  reg          ext_r;
  reg          dfirst_r;
  wire [NUM_CS-1:0] cs_hit;

  // ----------------------------------------
  // straps, caught on the cycle reset goes low
  // ----------------------------------------
  always @(posedge i_clk) begin
    rst_d_r <= i_rst;
    if (rst_d_r & ~i_rst) begin
      o_bus_mode_muxed <= i_bus_strap_port_bit;   // see RULE_01
      o_byte_order_big <= i_order_strap_port_bit; // see RULE_02
    end
  end
  // no reset value: the straps stay undefined until the first reset release
  // (mode and order are only loaded at release)

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_strap_port_in <= 2'h0;
    end else begin
      // after reset these are just port inputs again
      o_strap_port_in <= {i_order_strap_port_bit, i_bus_strap_port_bit}; // see RULE_03
    end
  end

  // ----------------------------------------
  // chip select decode
  // ----------------------------------------
  ebp_cs_decode #(
    .NUM_CS (NUM_CS),
    .AW     (AW)
  ) ebp_cs_decode_inst (
    .i_addr   (addr_r),
    .i_active (ext_r & ((state_r == ST_ADDR) | (state_r == ST_DATA))),
    .i_base   (i_cs_base),
    .i_mask   (i_cs_mask),
    .i_enable (i_cs_enable),
    .o_hit    (cs_hit)
  );

  // ----------------------------------------
  // bus controller state machine
  // ----------------------------------------
  // wait: high holds the cycle; ready sense: low holds until ready comes
  wire hold_cycle = i_ready_sense ? ~i_wait_in : i_wait_in; // see RULE_10 see RULE_11

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (i_bus_request_in) begin
          state_nxt = ST_DRAIN; // see RULE_12
        end else if (i_req & ~o_done) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        state_nxt = ST_DATA;
      end
      ST_DATA: begin
        // first data cycle always stands: the strobes only reach the pins at its end
        if (~dfirst_r & (~ext_r | ~hold_cycle)) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_DRAIN: begin
        state_nxt = i_bus_request_in ? ST_GRANT : ST_IDLE;
      end
      ST_GRANT: begin
        if (~i_bus_request_in) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      kind_r  <= `EBP_KIND_DUMMY;
      addr_r  <= {AW{1'b0}};
      wdata_r <= 16'h0000;
      be_r    <= 2'h0;
      ext_r   <= 1'b0;
      o_done  <= 1'b0;
      o_rdata <= 16'h0000;
      dfirst_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dfirst_r <= (state_r == ST_ADDR);
      o_done  <= (state_r == ST_DATA) & (state_nxt == ST_IDLE);
      if ((state_r == ST_IDLE) & (state_nxt == ST_ADDR)) begin
        kind_r  <= i_req_kind;
        addr_r  <= i_req_addr;
        wdata_r <= i_req_wdata;
        be_r    <= i_req_be;
        ext_r   <= i_req_external;
      end
      if ((state_r == ST_DATA) & (state_nxt == ST_IDLE) & (kind_r == `EBP_KIND_READ)) begin
        o_rdata <= i_data_lines_in;
      end
    end
  end

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  wire in_cyc   = ext_r & ((state_r == ST_ADDR) | (state_r == ST_DATA));
  wire in_data  = ext_r & (state_r == ST_DATA);
  // strobes drop on the exit edge, so read data is taken while they still stand
  wire strobe_on = in_data & (state_nxt == ST_DATA);
  wire is_rd    = (kind_r == `EBP_KIND_READ);
  wire is_wr    = (kind_r == `EBP_KIND_WRITE);
  wire granted  = (state_r == ST_GRANT) | (state_r == ST_DRAIN);
  wire muxed    = o_bus_mode_muxed;
  wire [15:0] dl_nxt;
  wire [15:0] dl_oe_nxt;
  wire [7:0]  p2_nxt;
  wire [7:0]  p2_oe_nxt;

  // data lines: muxed mode shows address in the address phase
  wire [15:0] bus_dl    = (muxed & (state_r == ST_ADDR)) ? addr_r[15:0] : wdata_r; // see RULE_15
  wire        bus_dl_dr = in_cyc & ((muxed & (state_r == ST_ADDR)) | (in_data & is_wr));
  // port two: address 16-23 in separate mode, 0-7 in muxed mode
  wire [7:0]  bus_p2    = muxed ? addr_r[7:0] : addr_r[23:16]; // see RULE_14 see RULE_15

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_dl
      // bus function only where selected, else the port bit with its own direction
      assign dl_nxt[g]    = i_bus_fn_sel[0] ? bus_dl[g] : i_port_out[g];         // see RULE_19
      assign dl_oe_nxt[g] = i_bus_fn_sel[0] ? ~(bus_dl_dr & ~granted)
                                            : ~i_port_dir[g];                    // see RULE_16
    end
    for (g = 0; g < 8; g = g + 1) begin : g_p2
      assign p2_nxt[g]    = i_bus_fn_sel[1] ? bus_p2[g] : i_port_out[16+g];      // see RULE_19
      assign p2_oe_nxt[g] = i_bus_fn_sel[1] ? granted : ~i_port_dir[16+g];       // see RULE_16
    end
  endgenerate

  reg sclk_src_r;

  always @(posedge i_clk) begin
    if (i_rst) begin
      o_data_lines_out           <= 16'h0000;
      o_data_lines_oe_n          <= 16'hFFFF;
      o_port_two_bits_out        <= 8'h00;
      o_port_two_bits_oe_n       <= 8'hFF;
      o_sep_addr_low             <= 16'h0000;
      o_read_strobe_n            <= 1'b1;
      o_low_write_strobe_n       <= 1'b1;
      o_high_byte_write_strobe_n <= 1'b1;
      o_read_write               <= 1'b1;
      o_addr_latch               <= 1'b0;
      o_chip_select_n            <= {NUM_CS{1'b1}};
      o_bus_grant_out            <= 1'b0;
      o_system_clock_out         <= 1'b0;
      sclk_src_r                 <= 1'b0;
    end else begin
      o_data_lines_out     <= dl_nxt;
      o_data_lines_oe_n    <= dl_oe_nxt;
      o_port_two_bits_out  <= p2_nxt;
      o_port_two_bits_oe_n <= p2_oe_nxt;
      o_sep_addr_low       <= muxed ? 16'h0000 : addr_r[15:0]; // see RULE_14
      if (i_bus_fn_sel[2]) begin
        o_read_strobe_n            <= ~(strobe_on & is_rd);               // see RULE_06
        o_low_write_strobe_n       <= ~(strobe_on & is_wr & be_r[0]);     // see RULE_07
        o_high_byte_write_strobe_n <= ~(strobe_on & is_wr & be_r[1]);     // see RULE_08
        o_read_write               <= ~(in_cyc & is_wr);                  // see RULE_05
        o_addr_latch               <= ext_r & (state_r == ST_ADDR);       // see RULE_09
      end else begin
        // read and low write strobes become output-only port bits when strobes are not selected
        o_read_strobe_n            <= i_strobe_port_out[0];               // see RULE_17
        o_low_write_strobe_n       <= i_strobe_port_out[1];               // see RULE_17
        o_high_byte_write_strobe_n <= 1'b1;
        o_read_write               <= 1'b1;
        o_addr_latch               <= 1'b0;
      end
      o_chip_select_n <= i_bus_fn_sel[3] ? ~cs_hit : {NUM_CS{1'b1}};       // see RULE_04
      // grant only once drivers are already released, one cycle later
      o_bus_grant_out <= (state_r == ST_GRANT);                            // see RULE_13
      sclk_src_r         <= i_clk_sel_slow;
      o_system_clock_out <= sclk_src_r ? i_slow_clk_lvl : i_fast_clk_lvl;  // see RULE_18
    end
  end

endmodule // ebp_bus_pins
`default_nettype wire

// >>> verification/ebp_mem_model.sv
/*
  external memory model: one word per low address byte, wait/ready pin.
  assumes the bus pins block drives the strobes and the latch strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module ebp_mem_model (
  input  wire logic        clk,
  input  wire logic        rd_n,
  input  wire logic        wl_n,
  input  wire logic        wh_n,
  input  wire logic        ale,
  input  wire logic        mux,
  input  wire logic        rdy,
  input  wire logic [3:0]  nwait,
  input  wire logic [15:0] dout,
  input  wire logic [15:0] sa,
  output logic      [15:0] din,
  output logic             wt
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0;
  logic [7:0]  a = 8'h0;
  logic [3:0]  cnt = 4'h0;
  logic        idle;
  assign idle = rd_n && wl_n && wh_n;
  always @(posedge clk) begin
    if (ale) a <= mux ? dout[7:0] : sa[7:0];
    if (!wl_n) mem[a][7:0] <= dout[7:0];
    if (!wh_n) mem[a][15:8] <= dout[15:8];
    if (!rd_n) last <= din;
    cnt <= idle ? nwait : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
  end
  // released lines show the inverse of the last word, never a stale match
  assign din = !rd_n ? mem[a] : ~last;
  assign wt = rdy ^ (!idle && cnt != 4'h0);
endmodule // ebp_mem_model
`default_nettype wire

// >>> verification/ebp_bus_pins_assertions.sv
/*
  checker for the bus pins block, bound to its top.
  assumes the core holds each request until done.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ebp_defs.vh"
module ebp_bus_pins_assertions (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_req,
  input wire logic [1:0]  i_req_kind,
  input wire logic [1:0]  i_req_be,
  input wire logic        i_req_external,
  input wire logic        i_wait_in,
  input wire logic        i_ready_sense,
  input wire logic        i_bus_request_in,
  input wire logic [3:0]  i_bus_fn_sel,
  input wire logic        o_bus_grant_out,
  input wire logic [15:0] o_data_lines_oe_n,
  input wire logic        o_read_strobe_n,
  input wire logic        o_low_write_strobe_n,
  input wire logic        o_high_byte_write_strobe_n,
  input wire logic        o_read_write,
  input wire logic        o_addr_latch,
  input wire logic [3:0]  o_chip_select_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_rd_rw; !o_read_strobe_n |-> o_read_write; endproperty
  a_rd_rw: assert property (p_rd_rw) else $error("read strobe with write level");
  property p_wr_rw; !o_low_write_strobe_n && i_bus_fn_sel[2] && $past(i_bus_fn_sel[2])
    |-> !o_read_write; endproperty
  a_wr_rw: assert property (p_wr_rw) else $error("write strobe with read level");
  property p_lwr; !o_low_write_strobe_n && i_bus_fn_sel[2] && $past(i_bus_fn_sel[2])
    |-> i_req_be[0] && i_req_kind == `EBP_KIND_WRITE; endproperty
  a_lwr: assert property (p_lwr) else $error("low write strobe without low byte");
  property p_hwr; !o_high_byte_write_strobe_n && i_bus_fn_sel[2] && $past(i_bus_fn_sel[2])
    |-> i_req_be[1] && !o_read_write; endproperty
  a_hwr: assert property (p_hwr) else $error("high write strobe without high byte");
  property p_ale; o_addr_latch |-> i_req && i_req_external; endproperty
  a_ale: assert property (p_ale) else $error("latch strobe on internal access");
  property p_cs; o_chip_select_n != 4'hF |-> i_req_external; endproperty
  a_cs: assert property (p_cs) else $error("chip select outside external cycle");
  property p_hold; (!o_read_strobe_n && !i_ready_sense && i_wait_in)[*2] |=> !o_read_strobe_n;
  endproperty
  a_hold: assert property (p_hold) else $error("cycle ended while wait held");
  property p_grant; o_bus_grant_out |-> o_data_lines_oe_n == 16'hFFFF; endproperty
  a_grant: assert property (p_grant) else $error("grant while drivers on");
  property p_drop; o_bus_grant_out && !i_bus_request_in |-> ##[1:3] !o_bus_grant_out;
  endproperty
  a_drop: assert property (p_drop) else $error("grant kept after request dropped");
endmodule // ebp_bus_pins_assertions
bind ebp_bus_pins ebp_bus_pins_assertions ebp_bus_pins_assertions_inst (.*);
`default_nettype wire

// >>> verification/ebp_bus_pins_bench.sv
/*
  self-checking bench for the bus pins block with a memory model.
  assumes a 40 MHz clock and synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ebp_defs.vh"
module ebp_bus_pins_bench;
  logic i_clk = 0, i_rst = 1, i_bus_strap_port_bit = 0, i_order_strap_port_bit = 0;
  logic i_req = 0, i_req_external = 1, i_ready_sense = 0, i_bus_request_in = 0;
  logic i_fast_clk_lvl = 0, i_slow_clk_lvl = 1, i_clk_sel_slow = 0, i_wait_in;
  logic [1:0] i_req_kind = 2'h0, i_req_be = 2'h3, i_strobe_port_out = 2'h0, o_strap_port_in;
  logic [23:0] i_req_addr = 24'h0, i_port_out = 24'hA5C33C, i_port_dir = 24'hF0F0F0;
  logic [15:0] i_req_wdata = 16'h0, i_data_lines_in, o_rdata, o_data_lines_out;
  logic [15:0] o_data_lines_oe_n, o_sep_addr_low, ad_seen;
  logic [95:0] i_cs_base = {24'h300000, 24'h200000, 24'h100000, 24'h000000};
  logic [95:0] i_cs_mask = {4{24'hF00000}};
  logic [3:0] i_cs_enable = 4'hF, i_bus_fn_sel = 4'hF, o_chip_select_n, cs_seen, nwait = 4'h0;
  logic [7:0] o_port_two_bits_out, o_port_two_bits_oe_n, p2_seen;
  logic o_bus_mode_muxed, o_byte_order_big, o_done, o_bus_grant_out, o_read_strobe_n;
  logic o_low_write_strobe_n, o_high_byte_write_strobe_n, o_read_write, o_addr_latch;
  logic o_system_clock_out;
  int fail_count = 0, cmp_count = 0, cyc = 0, n;
  ebp_bus_pins ebp_bus_pins_inst (.*);
  ebp_mem_model ebp_mem_model_inst (.clk(i_clk), .rd_n(o_read_strobe_n),
    .wl_n(o_low_write_strobe_n), .wh_n(o_high_byte_write_strobe_n), .ale(o_addr_latch),
    .mux(o_bus_mode_muxed), .rdy(i_ready_sense), .nwait(nwait), .dout(o_data_lines_out),
    .sa(o_sep_addr_low), .din(i_data_lines_in), .wt(i_wait_in));
  always #12.5 i_clk = ~i_clk;
  // cut a hang short well past the expected hundred or so cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      finish_test;
    end
  end
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task do_reset(input logic b, input logic o);
    @(posedge i_clk);
    i_bus_strap_port_bit <= b;
    i_order_strap_port_bit <= o;
    i_rst <= 1;
    repeat (4) @(posedge i_clk);
    i_rst <= 0;
    repeat (2) @(posedge i_clk);
    #1;
    check("bus_mode", o_bus_mode_muxed, b);
    check("byte_order", o_byte_order_big, o);
  endtask
  task op(input logic [1:0] k, input logic [23:0] a, input logic [15:0] d,
          input logic [1:0] be, input logic ext);
    @(posedge i_clk);
    {i_req, i_req_kind, i_req_addr, i_req_wdata, i_req_be, i_req_external} <= {1'b1, k, a, d, be, ext};
    {n, cs_seen, ad_seen, p2_seen} = {32'h0, 4'hF, 16'h0, 8'h0};
    do begin
      @(posedge i_clk);
      #1;
      n++;
      if (o_addr_latch) {cs_seen, ad_seen, p2_seen} = {o_chip_select_n, o_data_lines_out, o_port_two_bits_out};
    end while (!o_done && n < 40);
    @(posedge i_clk);
    i_req <= 0;
  endtask
  task t_strap;
    do_reset(1, 0);
    @(posedge i_clk);
    {i_bus_strap_port_bit, i_order_strap_port_bit} <= 2'h1;
    repeat (3) @(posedge i_clk);
    #1;
    check("mode_kept", o_bus_mode_muxed, 1'b1);
    check("order_kept", o_byte_order_big, 1'b0);
    check("strap_port", o_strap_port_in, 2'h2);
    $display("test strap done");
  endtask
  task t_muxed;
    op(`EBP_KIND_WRITE, 24'h1012AB, 16'hBEEF, 2'h3, 1);
    check("mux_lat", n, 4);
    check("mux_addr", ad_seen, 16'h12AB);
    check("mux_p2", p2_seen, 8'hAB);
    check("cs1", cs_seen, 4'hD);
    op(`EBP_KIND_READ, 24'h1012AB, 16'h0, 2'h3, 1);
    check("mux_rd", o_rdata, 16'hBEEF);
    $display("test muxed done");
  endtask
  task t_sep;
    do_reset(0, 1);
    op(`EBP_KIND_WRITE, 24'h3000AB, 16'h1234, 2'h1, 1);
    check("cs3", cs_seen, 4'h7);
    op(`EBP_KIND_WRITE, 24'h3000AB, 16'h5600, 2'h2, 1);
    op(`EBP_KIND_READ, 24'h3000AB, 16'h0, 2'h3, 1);
    check("sep_rd", o_rdata, 16'h5634);
    $display("test separate done");
  endtask
  task t_wait;
    nwait = 4'h3;
    op(`EBP_KIND_READ, 24'h3000AB, 16'h0, 2'h3, 1);
    check("wait_len", n >= 7 && n <= 9, 1'b1);
    i_ready_sense <= 1;
    op(`EBP_KIND_READ, 24'h3000AB, 16'h0, 2'h3, 1);
    check("ready_len", n >= 7 && n <= 9, 1'b1);
    check("ready_rd", o_rdata, 16'h5634);
    nwait = 4'h0;
    i_ready_sense <= 0;
    $display("test wait done");
  endtask
  task t_internal;
    op(`EBP_KIND_READ, 24'h1000AB, 16'h0, 2'h3, 0);
    check("int_lat", n, 4);
    check("int_cs", cs_seen, 4'hF);
    op(`EBP_KIND_DUMMY, 24'h2000AB, 16'h0, 2'h3, 1);
    check("dummy_lat", n, 4);
    check("dummy_cs", cs_seen, 4'hB);
    $display("test internal done");
  endtask
  task t_grant;
    @(posedge i_clk);
    i_bus_request_in <= 1;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (!o_bus_grant_out && n < 10);
    check("grant_lat", n, 3);
    check("grant_oe", o_data_lines_oe_n, 16'hFFFF);
    @(posedge i_clk);
    i_bus_request_in <= 0;
    repeat (3) @(posedge i_clk);
    #1;
    check("grant_off", o_bus_grant_out, 1'b0);
    $display("test grant done");
  endtask
  task t_port_clk;
    @(posedge i_clk);
    i_bus_fn_sel <= 4'h0;
    i_clk_sel_slow <= 1;
    i_strobe_port_out <= 2'h1;
    repeat (2) @(posedge i_clk);
    #1;
    check("rd_port", o_read_strobe_n, 1'b1);
    check("wr_port", o_low_write_strobe_n, 1'b0);
    check("p2_out", o_port_two_bits_out, 8'hA5);
    check("p2_dir", o_port_two_bits_oe_n, 8'h0F);
    check("sclk_slow", o_system_clock_out, 1'b1);
    @(posedge i_clk);
    i_clk_sel_slow <= 0;
    i_bus_fn_sel <= 4'hF;
    repeat (2) @(posedge i_clk);
    #1;
    check("sclk_fast", o_system_clock_out, 1'b0);
    $display("test port and clock done");
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    t_strap;
    t_muxed;
    t_sep;
    t_wait;
    t_internal;
    t_grant;
    t_port_clk;
    finish_test;
  end
endmodule // ebp_bus_pins_bench
`default_nettype wire
